// *** rtl/alp_adc_lpm.sv ***
`timescale 1ns/1ps
// Overview of operation
// - With the asynchronous clock selected, conversion keeps running in stop3.
// - A conversion in flight when stop3 begins finishes normally.
// - In stop3, hardware triggers and continuous mode still start conversions.
// - Completion sets the complete flag; with interrupt enable, raises a waking interrupt.
// - Stop3 operation needs both low-voltage detect enable bits set.
// - Entering stop1 or stop2 disables the converter automatically.
// - After stop1 or stop2 every converter register holds its reset value.
// - Configuration selects clock source, divider, sample time and low-power bias.
// - 8-bit and 10-bit resolutions; 10-bit gives 1024 codes.
// - Exactly two analog pin enable registers.
// - Temperature sensor sits on one analog channel, converted like others.
module alp_adc_lpm #(
	parameter int PIN_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input alp_pkg::alp_pwr_t pwr_mode,
	input wire logic lowvolt_detect_en,
	input wire logic lowvolt_detect_stop_en,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] converter_config_reg,
	input wire logic ctl_wr,
	input wire logic [7:0] ctl_wdata,
	output logic [7:0] ctl_rdata,
	input wire logic pin_lo_wr,
	input wire logic pin_hi_wr,
	input wire logic [PIN_W-1:0] pin_wdata,
	output logic [PIN_W-1:0] analog_pin_enable_lo,
	output logic [PIN_W-1:0] analog_pin_enable_hi,
	input wire logic alt_clk_tick,
	input wire logic async_conv_clock,
	input wire logic hw_trigger,
	input wire logic cmp_hi,
	output logic [9:0] dac_code,
	output logic [4:0] chan_sel,
	output logic temp_sensor_en,
	output logic lowpwr_bias,
	output logic conv_active,
	input wire logic result_rd,
	output logic [9:0] result,
	output logic conv_complete_flag,
	output logic conv_irq,
	output logic stop3_wake,
	output logic stop3_ok
);
	if (PIN_W < 1 || PIN_W > 8) begin : g_chk
		$error("PIN_W must be 1 to 8");
	end

	alp_conv_if cif ();

	logic [7:0] cfg_r, cfg_nxt;
	logic [7:0] ctl_r, ctl_nxt;
	logic [PIN_W-1:0] pin_lo_r, pin_lo_nxt;
	logic [PIN_W-1:0] pin_hi_r, pin_hi_nxt;
	logic trg_d_r, trg_d_nxt;
	logic pend_r, pend_nxt;
	logic flag_r, flag_nxt;
	logic div2_r, div2_nxt;
	logic deep_stop, in_stop3, run_ok, chan_off, ien, cont, trg_mode;
	logic async_sel, div_tick, hw_rise, start_ok;
	logic [3:0] src_tick;

	assign deep_stop = (pwr_mode == alp_pkg::ALP_PWR_STOP1)
		|| (pwr_mode == alp_pkg::ALP_PWR_STOP2);
	assign in_stop3 = (pwr_mode == alp_pkg::ALP_PWR_STOP3);
	assign async_sel = (cfg_r[alp_pkg::ALP_CFG_CLK_LSB +: 2] == alp_pkg::ALP_CLK_ASYNC);
	assign stop3_ok = async_sel && lowvolt_detect_en && lowvolt_detect_stop_en;
	assign run_ok = !in_stop3 || stop3_ok;
	assign chan_off = (ctl_r[alp_pkg::ALP_CTL_CH_LSB +: 5] == alp_pkg::ALP_CH_OFF);
	assign ien = ctl_r[alp_pkg::ALP_CTL_IEN_BIT];
	assign cont = ctl_r[alp_pkg::ALP_CTL_CONT_BIT];
	assign trg_mode = ctl_r[alp_pkg::ALP_CTL_TRG_BIT];
	assign hw_rise = hw_trigger && !trg_d_r;

	// Bus-derived clocks stop in stop3; only the asynchronous clock keeps ticking
	assign src_tick = {async_conv_clock, alt_clk_tick && !in_stop3,
		div2_r && !in_stop3, !in_stop3};

	alp_clk_div u_div (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.clr(cif.clr),
		.src_tick(src_tick),
		.src_sel(cfg_r[alp_pkg::ALP_CFG_CLK_LSB +: 2]),
		.div_sel(cfg_r[alp_pkg::ALP_CFG_DIV_LSB +: 2]),
		.tick(div_tick)
	);

	// Stop1/stop2 forces the engine idle; turning the channel off also aborts
	assign cif.clr = deep_stop || chan_off;
	// Unsupported stop3 freezes the conversion instead of corrupting it
	assign cif.tick = div_tick && run_ok;
	assign start_ok = pend_r && !cif.busy && run_ok;
	assign cif.start = start_ok;
	assign cif.long_smp = cfg_r[alp_pkg::ALP_CFG_LSMP_BIT];
	assign cif.ten_bit = (cfg_r[alp_pkg::ALP_CFG_MODE_LSB +: 2] == alp_pkg::ALP_MODE_10);
	assign cif.cmp_hi = cmp_hi;

	alp_sar u_sar (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.cif(cif)
	);

	always_comb begin
		cfg_nxt = cfg_r;
		ctl_nxt = ctl_r;
		pin_lo_nxt = pin_lo_r;
		pin_hi_nxt = pin_hi_r;
		trg_d_nxt = hw_trigger;
		div2_nxt = !div2_r;
		pend_nxt = pend_r;
		flag_nxt = flag_r;
		if (cfg_wr) begin
			cfg_nxt = cfg_wdata;
		end
		if (pin_lo_wr) begin
			pin_lo_nxt = pin_wdata;
		end
		if (pin_hi_wr) begin
			pin_hi_nxt = pin_wdata;
		end
		if (start_ok) begin
			pend_nxt = 1'b0;
		end
		if (trg_mode && hw_rise && !chan_off) begin
			pend_nxt = 1'b1;
		end
		if (cif.done && cont && !chan_off) begin
			pend_nxt = 1'b1;
		end
		if (ctl_wr) begin
			ctl_nxt = ctl_wdata;
			pend_nxt = !ctl_wdata[alp_pkg::ALP_CTL_TRG_BIT]
				&& (ctl_wdata[alp_pkg::ALP_CTL_CH_LSB +: 5] != alp_pkg::ALP_CH_OFF);
		end
		// A completion in the same cycle as a clear keeps the flag set
		if (result_rd || ctl_wr) begin
			flag_nxt = 1'b0;
		end
		if (cif.done) begin
			flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b || deep_stop) begin
			cfg_r <= alp_pkg::ALP_CFG_RST;
			ctl_r <= alp_pkg::ALP_CTL_RST;
			pin_lo_r <= PIN_W'(alp_pkg::ALP_PIN_RST);
			pin_hi_r <= PIN_W'(alp_pkg::ALP_PIN_RST);
			trg_d_r <= 1'b0;
			pend_r <= 1'b0;
			flag_r <= 1'b0;
			div2_r <= 1'b0;
		end else if (clk_en) begin
			cfg_r <= cfg_nxt;
			ctl_r <= ctl_nxt;
			pin_lo_r <= pin_lo_nxt;
			pin_hi_r <= pin_hi_nxt;
			trg_d_r <= trg_d_nxt;
			pend_r <= pend_nxt;
			flag_r <= flag_nxt;
			div2_r <= div2_nxt;
		end
	end

	assign converter_config_reg = cfg_r;
	assign ctl_rdata = ctl_r;
	assign analog_pin_enable_lo = pin_lo_r;
	assign analog_pin_enable_hi = pin_hi_r;
	assign chan_sel = ctl_r[alp_pkg::ALP_CTL_CH_LSB +: 5];
	assign temp_sensor_en = (chan_sel == alp_pkg::ALP_CH_TEMP);
	assign lowpwr_bias = cfg_r[alp_pkg::ALP_CFG_LPC_BIT];
	assign conv_active = cif.busy;
	assign dac_code = cif.dac_code;
	assign result = cif.result;
	assign conv_complete_flag = flag_r;
	assign conv_irq = flag_r && ien;
	assign stop3_wake = conv_irq && in_stop3;

	sequence s_enter_stop3;
		!in_stop3 && cif.busy && stop3_ok ##1 in_stop3 && stop3_ok && !cif.clr;
	endsequence

	sequence s_hw_start;
		trg_mode && hw_rise && !chan_off && !cif.busy && !pend_r && run_ok && !deep_stop
			&& !ctl_wr ##1 run_ok && !cif.clr;
	endsequence

	// Unsupported stop3 with a conversion in flight: no tick, no clear
	sequence s_frozen;
		in_stop3 && !stop3_ok && cif.busy && !cif.clr;
	endsequence

	a_flag_on_done: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		cif.done && !deep_stop |=> conv_complete_flag)
		else $error("complete flag not set after conversion");

	a_irq_on_done: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		cif.done && ien && !deep_stop && !ctl_wr |=> conv_irq && (stop3_wake == in_stop3))
		else $error("interrupt or wake missing after completion");

	a_flag_clear: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		result_rd && !cif.done |=> !conv_complete_flag)
		else $error("complete flag not cleared by result read");

	a_stop3_finish: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		s_enter_stop3 |-> cif.busy || cif.done)
		else $error("conversion aborted on stop3 entry");

	a_stop3_freeze: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		s_frozen |=> conv_active && $stable(dac_code))
		else $error("conversion advanced or lost in unsupported stop3");

	a_stop3_trig: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		s_hw_start |=> cif.busy)
		else $error("hardware trigger did not start a conversion");

	a_cont_restart: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		cif.done && cont && !cif.clr && !deep_stop && !ctl_wr |=> pend_r)
		else $error("continuous mode did not rearm");

	a_lvd_gate: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		in_stop3 && !(lowvolt_detect_en && lowvolt_detect_stop_en) |-> !cif.tick)
		else $error("conversion clock runs in unsupported stop3");

	a_async_only: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		in_stop3 && cif.tick |-> async_sel && async_conv_clock)
		else $error("non-asynchronous clock ticked in stop3");

	a_deep_reset: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		deep_stop |=> converter_config_reg == alp_pkg::ALP_CFG_RST
			&& ctl_rdata == alp_pkg::ALP_CTL_RST && !conv_complete_flag
			&& !conv_active)
		else $error("registers not reset in stop1 or stop2");

	// Checked without clk_en: deep stop must reset even while frozen
	a_deep_pins: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		deep_stop |=> analog_pin_enable_lo == PIN_W'(alp_pkg::ALP_PIN_RST)
			&& analog_pin_enable_hi == PIN_W'(alp_pkg::ALP_PIN_RST) && !conv_irq)
		else $error("pin enables not reset in stop1 or stop2");

	a_cfg_write: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		cfg_wr && !deep_stop ##1 !deep_stop |-> converter_config_reg == $past(cfg_wdata))
		else $error("configuration write lost");

	a_pin_write: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		pin_hi_wr && !deep_stop ##1 !deep_stop |-> analog_pin_enable_hi == $past(pin_wdata))
		else $error("pin enable write lost");

	a_lo_write: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		pin_lo_wr && !deep_stop ##1 !deep_stop |-> analog_pin_enable_lo == $past(pin_wdata))
		else $error("low pin enable write lost");

	a_chan_write: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		ctl_wr && !deep_stop ##1 !deep_stop
			|-> chan_sel == $past(ctl_wdata[alp_pkg::ALP_CTL_CH_LSB +: 5]))
		else $error("channel selection write lost");

	a_res_width: assert property (@(posedge ref_clk)
		disable iff (!rst_b || !clk_en)
		cif.done && !cif.ten_bit |-> result[9:8] == 2'h0)
		else $error("8-bit result wider than 8 bits");

endmodule // alp_adc_lpm

// *** common/alp_pkg.sv ***
package alp_pkg;

	typedef enum logic [2:0] {
		ALP_PWR_RUN,
		ALP_PWR_WAIT,
		ALP_PWR_STOP1,
		ALP_PWR_STOP2,
		ALP_PWR_STOP3
	} alp_pwr_t;

	// Converter configuration register layout
	localparam int ALP_CFG_CLK_LSB = 0;
	localparam int ALP_CFG_MODE_LSB = 2;
	localparam int ALP_CFG_LSMP_BIT = 4;
	localparam int ALP_CFG_DIV_LSB = 5;
	localparam int ALP_CFG_LPC_BIT = 7;
	localparam logic [7:0] ALP_CFG_RST = 8'h00;

	// Conversion control register layout
	localparam int ALP_CTL_CH_LSB = 0;
	localparam int ALP_CTL_CONT_BIT = 5;
	localparam int ALP_CTL_TRG_BIT = 6;
	localparam int ALP_CTL_IEN_BIT = 7;
	localparam logic [7:0] ALP_CTL_RST = 8'h1F;

	localparam logic [7:0] ALP_PIN_RST = 8'h00;

	// Clock sources: bus, bus/2, alternate, asynchronous conversion clock
	localparam logic [1:0] ALP_CLK_BUS = 2'h0;
	localparam logic [1:0] ALP_CLK_BUS2 = 2'h1;
	localparam logic [1:0] ALP_CLK_ALT = 2'h2;
	localparam logic [1:0] ALP_CLK_ASYNC = 2'h3;

	localparam logic [1:0] ALP_MODE_10 = 2'h2;

	localparam logic [4:0] ALP_CH_OFF = 5'h1F;
	localparam logic [4:0] ALP_CH_TEMP = 5'h1A;

	localparam int ALP_RES_W = 10;
	localparam logic [9:0] ALP_MSB_ONEHOT = 10'h200;

	// Sample phase length in conversion clock ticks
	localparam logic [4:0] ALP_SMP_SHORT = 5'h02;
	localparam logic [4:0] ALP_SMP_LONG = 5'h14;

endpackage

// *** common/alp_conv_if.sv ***
`timescale 1ns/1ps
interface alp_conv_if;
	logic clr;
	logic tick;
	logic start;
	logic long_smp;
	logic ten_bit;
	logic cmp_hi;
	logic busy;
	logic done;
	logic [9:0] result;
	logic [9:0] dac_code;

	modport ctrl (
		output clr,
		output tick,
		output start,
		output long_smp,
		output ten_bit,
		output cmp_hi,
		input busy,
		input done,
		input result,
		input dac_code
	);

	modport eng (
		input clr,
		input tick,
		input start,
		input long_smp,
		input ten_bit,
		input cmp_hi,
		output busy,
		output done,
		output result,
		output dac_code
	);
endinterface

// *** rtl/alp_clk_div.sv ***
`timescale 1ns/1ps
module alp_clk_div (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic clr,
	input wire logic [3:0] src_tick,
	input wire logic [1:0] src_sel,
	input wire logic [1:0] div_sel,
	output logic tick
);
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic [2:0] limit;
	logic src;

	assign src = src_tick[src_sel];
	assign limit = 3'((4'h1 << div_sel) - 4'h1);
	assign tick = src && (cnt_r == limit);

	always_comb begin
		cnt_nxt = cnt_r;
		if (src) begin
			cnt_nxt = (cnt_r == limit) ? 3'h0 : cnt_r + 3'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b || clr) begin
			cnt_r <= 3'h0;
		end else if (clk_en) begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule // alp_clk_div

// *** rtl/alp_sar.sv ***
`timescale 1ns/1ps
module alp_sar (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	alp_conv_if.eng cif
);
	typedef enum logic [1:0] {ALP_S_IDLE, ALP_S_SAMPLE, ALP_S_CONV} alp_sar_st_t;

	alp_sar_st_t st_r, st_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [9:0] code_r, code_nxt;
	logic [9:0] bit_r, bit_nxt;
	logic [9:0] res_r, res_nxt;
	logic done_r, done_nxt;
	logic [9:0] kept;
	logic last;

	assign cif.busy = (st_r != ALP_S_IDLE);
	assign cif.done = done_r;
	assign cif.result = res_r;
	assign cif.dac_code = code_r;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		code_nxt = code_r;
		bit_nxt = bit_r;
		res_nxt = res_r;
		done_nxt = 1'b0;
		kept = cif.cmp_hi ? code_r : (code_r & ~bit_r);
		// 8-bit mode resolves bits 9..2 only
		last = cif.ten_bit ? bit_r[0] : bit_r[2];
		case (st_r)
			ALP_S_IDLE: begin
				if (cif.start) begin
					st_nxt = ALP_S_SAMPLE;
					cnt_nxt = cif.long_smp ? alp_pkg::ALP_SMP_LONG - 5'h01
						: alp_pkg::ALP_SMP_SHORT - 5'h01;
				end
			end
			ALP_S_SAMPLE: begin
				if (cif.tick) begin
					if (cnt_r == 5'h00) begin
						st_nxt = ALP_S_CONV;
						bit_nxt = alp_pkg::ALP_MSB_ONEHOT;
						code_nxt = alp_pkg::ALP_MSB_ONEHOT;
					end else begin
						cnt_nxt = cnt_r - 5'h01;
					end
				end
			end
			ALP_S_CONV: begin
				if (cif.tick) begin
					if (last) begin
						st_nxt = ALP_S_IDLE;
						done_nxt = 1'b1;
						code_nxt = kept;
						res_nxt = cif.ten_bit ? kept : {2'h0, kept[9:2]};
					end else begin
						bit_nxt = bit_r >> 1;
						code_nxt = kept | (bit_r >> 1);
					end
				end
			end
			default: st_nxt = ALP_S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b || cif.clr) begin
			st_r <= ALP_S_IDLE;
			cnt_r <= 5'h00;
			code_r <= 10'h000;
			bit_r <= 10'h000;
			res_r <= 10'h000;
			done_r <= 1'b0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			code_r <= code_nxt;
			bit_r <= bit_nxt;
			res_r <= res_nxt;
			done_r <= done_nxt;
		end
	end
endmodule // alp_sar

// *** test/alp_pwr_partner.sv ***
`timescale 1ns/1ps
module alp_pwr_partner (
	input wire logic ref_clk,
	input wire logic rst_b,
	input alp_pkg::alp_pwr_t mode_req,
	input wire logic trig_req,
	input wire logic [9:0] analog,
	input wire logic [9:0] dac_code,
	output alp_pkg::alp_pwr_t pwr_mode,
	output logic async_conv_clock,
	output logic alt_clk_tick,
	output logic hw_trigger,
	output logic cmp_hi
);
	logic [1:0] div_r;
	// Result blocking not modelled, nothing to clear on stop3 entry
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			div_r <= 2'h0;
			pwr_mode <= alp_pkg::ALP_PWR_RUN;
			hw_trigger <= 1'b0;
		end else begin
			div_r <= div_r + 2'h1;
			pwr_mode <= mode_req;
			hw_trigger <= trig_req;
		end
	end
	// Async source keeps ticking in every stop mode
	assign async_conv_clock = (div_r == 2'h3);
	// Alternate source dies outside run, like a real bus-derived clock
	assign alt_clk_tick = div_r[0] && (pwr_mode == alp_pkg::ALP_PWR_RUN);
	assign cmp_hi = (analog >= dac_code);
endmodule // alp_pwr_partner

// *** test/alp_adc_lpm_tb.sv ***
`timescale 1ns/1ps
module alp_adc_lpm_tb;
	logic ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, lv_en = 1'b0, lv_st = 1'b0;
	logic cfg_wr = 1'b0, ctl_wr = 1'b0, plo_wr = 1'b0, phi_wr = 1'b0, rd = 1'b0, trig = 1'b0;
	logic [7:0] cfg_wd = 8'h00, ctl_wd = 8'h00, pin_wd = 8'h00, cfg_q, ctl_q, plo_q, phi_q;
	logic [9:0] analog = 10'h000, dac, res;
	logic [4:0] ch;
	logic alt_t, async_t, hwt, cmp, tmp, lpb, act, flag, irq, wake, ok;
	alp_pkg::alp_pwr_t mode_req = alp_pkg::ALP_PWR_RUN, pwr;
	int num_errors = 0, checked = 0;

	always #4 ref_clk = ~ref_clk;

	alp_pwr_partner PM (.ref_clk(ref_clk), .rst_b(rst_b), .mode_req(mode_req), .trig_req(trig),
		.analog(analog), .dac_code(dac), .pwr_mode(pwr), .async_conv_clock(async_t),
		.alt_clk_tick(alt_t), .hw_trigger(hwt), .cmp_hi(cmp));

	alp_adc_lpm DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .pwr_mode(pwr),
		.lowvolt_detect_en(lv_en), .lowvolt_detect_stop_en(lv_st), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wd), .converter_config_reg(cfg_q), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wd),
		.ctl_rdata(ctl_q), .pin_lo_wr(plo_wr), .pin_hi_wr(phi_wr), .pin_wdata(pin_wd),
		.analog_pin_enable_lo(plo_q), .analog_pin_enable_hi(phi_q), .alt_clk_tick(alt_t),
		.async_conv_clock(async_t), .hw_trigger(hwt), .cmp_hi(cmp), .dac_code(dac),
		.chan_sel(ch), .temp_sensor_en(tmp), .lowpwr_bias(lpb), .conv_active(act),
		.result_rd(rd), .result(res), .conv_complete_flag(flag), .conv_irq(irq),
		.stop3_wake(wake), .stop3_ok(ok));

	task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({9'h000, got}, {9'h000, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input int sel, input logic [7:0] v);
		@(posedge ref_clk);
		cfg_wr <= (sel == 0);
		ctl_wr <= (sel == 1);
		plo_wr <= (sel == 2);
		phi_wr <= (sel == 3);
		cfg_wd <= v;
		ctl_wd <= v;
		pin_wd <= v;
		@(posedge ref_clk);
		{cfg_wr, ctl_wr, plo_wr, phi_wr} <= 4'h0;
		#1;
	endtask

	task automatic wait_flag(input int lim);
		int i;
		for (i = 0; i < lim && flag !== 1'b1; i++)
			cyc(1);
		chk_bit(flag, 1'b1);
	endtask

	task automatic read_res();
		@(posedge ref_clk);
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		cyc(1);
		chk_bit(flag, 1'b0);
	endtask

	task automatic t_reset_regs();
		chk_val(cfg_q, 10'h000);
		chk_val(ctl_q, 10'h01F);
		chk_val(plo_q, 10'h000);
		chk_val(phi_q, 10'h000);
		chk_bit(flag, 1'b0);
	endtask

	task automatic t_config();
		wr(0, 8'hEB);
		chk_val(cfg_q, 10'h0EB);
		chk_bit(lpb, 1'b1);
		wr(0, 8'h08);
		chk_bit(lpb, 1'b0);
		wr(2, 8'hA5);
		wr(3, 8'h5A);
		chk_val(plo_q, 10'h0A5);
		chk_val(phi_q, 10'h05A);
	endtask

	task automatic t_conv_run();
		analog = 10'h2A5;
		wr(1, 8'h83);
		wait_flag(300);
		chk_val(res, 10'h2A5);
		chk_val(dac, 10'h2A5);
		chk_bit(irq, 1'b1);
		read_res();
		chk_bit(irq, 1'b0);
		analog = 10'h3FF;
		wr(1, 8'h83);
		wait_flag(300);
		chk_val(res, 10'h3FF);
		read_res();
		wr(0, 8'h00);
		wr(1, 8'h03);
		wait_flag(300);
		chk_val(res, 10'h0FF);
		chk_bit(irq, 1'b0);
		read_res();
	endtask

	task automatic t_stop3();
		analog = 10'h155;
		lv_en <= 1'b1;
		lv_st <= 1'b1;
		wr(0, 8'h0B);
		chk_bit(ok, 1'b1);
		wr(1, 8'h84);
		cyc(6);
		mode_req <= alp_pkg::ALP_PWR_STOP3;
		wait_flag(600);
		chk_val(res, 10'h155);
		chk_bit(wake, 1'b1);
		read_res();
		wr(1, 8'hC4);
		@(posedge ref_clk);
		trig <= 1'b1;
		cyc(2);
		trig <= 1'b0;
		wait_flag(600);
		read_res();
		wr(1, 8'hA4);
		wait_flag(600);
		read_res();
		wait_flag(600);
		wr(1, 8'h1F);
		mode_req <= alp_pkg::ALP_PWR_RUN;
		lv_st <= 1'b0;
		cyc(2);
		chk_bit(ok, 1'b0);
		wr(1, 8'h84);
		cyc(6);
		mode_req <= alp_pkg::ALP_PWR_STOP3;
		cyc(300);
		chk_bit(flag, 1'b0);
		mode_req <= alp_pkg::ALP_PWR_RUN;
		wait_flag(600);
		read_res();
	endtask

	task automatic t_deep_stop(input alp_pkg::alp_pwr_t m);
		wr(0, 8'h0B);
		wr(2, 8'hFF);
		wr(1, 8'h84);
		cyc(6);
		mode_req <= m;
		cyc(3);
		chk_bit(act, 1'b0);
		wr(0, 8'h55);
		mode_req <= alp_pkg::ALP_PWR_RUN;
		cyc(3);
		t_reset_regs();
	endtask

	task automatic t_temp();
		wr(0, 8'h08);
		analog = 10'h1C3;
		wr(1, 8'h1A);
		chk_val(ch, 10'h01A);
		chk_bit(tmp, 1'b1);
		wait_flag(300);
		chk_val(res, 10'h1C3);
		wr(1, 8'h1F);
		chk_bit(tmp, 1'b0);
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		cyc(8);
		rst_b <= 1'b1;
		cyc(1);
		t_reset_regs();
		t_config();
		t_conv_run();
		t_stop3();
		t_deep_stop(alp_pkg::ALP_PWR_STOP1);
		t_deep_stop(alp_pkg::ALP_PWR_STOP2);
		t_temp();
		print_verdict();
	end

	initial begin
		#400000;
		num_errors++;
		print_verdict();
	end
endmodule // alp_adc_lpm_tb
